// *** inc/image_map_pkg.sv ***
package image_map_pkg;
   // Image geometry
   localparam int NUM_CH          = 8;
   localparam int FULL_IN_BYTES   = 24;
   localparam int FULL_OUT_BYTES  = 24;
   localparam int ALIGN_BYTES     = 32;
   localparam int COMPACT_BYTES   = 16;
   localparam int STRIDE_PACKED   = 3;
   localparam int STRIDE_ALIGNED  = 4;
   localparam int COMPACT_STRIDE  = 2;
   // Status byte fields
   localparam int SB_ERR_BIT      = 6;
   localparam int SB_OVER_BIT     = 1;
   localparam int SB_UNDER_BIT    = 0;
   // Configuration register
   localparam logic [7:0] CFG_ADDR    = 8'h40;
   localparam logic [7:0] CFG_MASK    = 8'h03;
   localparam logic [7:0] CFG_RESET   = 8'h00;
   localparam int         CFG_COMPACT = 0;
   localparam int         CFG_ALIGN   = 1;
   // Per-channel register store
   localparam int MEM_AW    = 9;
   localparam int MEM_DEPTH = 512;

   typedef enum logic [1:0] {POS_BYTE, POS_LO, POS_HI, POS_PAD} field_pos_t;
   typedef enum logic {SVC_IDLE, SVC_READ} svc_state_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] ch;
      field_pos_t pos;
   } addr_dec_t;

   typedef struct packed {
      logic [15:0] value;
      logic        err;
      logic        over;
      logic        under;
   } chan_meas_t;

   typedef struct packed {
      logic       reg_mode_select;
      logic       rw;
      logic [5:0] reg_num;
   } ctrl_byte_t;
endpackage : image_map_pkg

// *** src/reg_store.sv ***
`timescale 1ns/1ps
module reg_store (
   input  wire logic                             core_clk_i,
   input  wire logic                             sys_rst_i,
   input  wire logic                             we_i,
   input  wire logic                             re_i,
   input  wire logic [image_map_pkg::MEM_AW-1:0] addr_i,
   input  wire logic [15:0]                      wdata_i,
   output logic      [15:0]                      rdata_o,
   output logic                                  busy_o
);
   import image_map_pkg::*;

   logic [15:0]       mem [MEM_DEPTH];
   logic [MEM_AW-1:0] clr_addr_reg;
   logic              busy_reg;
   logic [15:0]       rdata_reg;

   // Clearing sweep after reset
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         busy_reg     <= 1'b1;
         clr_addr_reg <= '0;
      end else if (busy_reg) begin
         clr_addr_reg <= clr_addr_reg + 1'b1;
         if (clr_addr_reg == MEM_AW'(MEM_DEPTH - 1)) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // Storage array
   always_ff @(posedge core_clk_i) begin
      if (busy_reg) begin
         mem[clr_addr_reg] <= '0;
      end else if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   // Registered read port
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         rdata_reg <= '0;
      end else if (re_i) begin
         rdata_reg <= mem[addr_i];
      end
   end

   assign rdata_o = rdata_reg;
   assign busy_o  = busy_reg;
endmodule : reg_store

// *** src/image_map.sv ***
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Full image carries 24 input bytes and 24 output bytes.
// [RULE2] Each channel status byte sits just before its input word. In the aligned layout the code puts a pad byte between them.
// [RULE3] Controller places each control byte just before its output word. In the aligned layout the code decodes a pad byte between them.
// [RULE4] Unaligned layout uses three-byte stride, last word at 22.
// [RULE5] Aligned layout uses four-byte stride, last word at 30.
// [RULE6] Compact image gives eight input words only, takes no output.
// [RULE7] Output words only carry register traffic, never process values.
// [RULE8] Control bit 7 selects register mode, bit 6 write, 5..0 number.
// [RULE9] Register mode acknowledges via status bit 7, echoes number, data.
// [RULE10] Process mode status: bit 6 error, 1 over, 0 under, 7 zero.
// [RULE11] All channels share one layout and work independently.
// [RULE12] Data words travel low byte first at the lower offset.
module image_map (
   input  wire logic                           core_clk_i,
   input  wire logic                           sys_rst_i,
   input  wire logic [7:0]                     bus_addr_i,
   input  wire logic [7:0]                     bus_wdata_i,
   input  wire logic                           bus_wr_i,
   input  wire logic                           bus_rd_i,
   input  wire image_map_pkg::chan_meas_t [7:0] chan_meas_i,
   output logic      [7:0]                     bus_rdata_o,
   output logic      [7:0]                     chan_reg_mode_o
);
   import image_map_pkg::*;

   logic [7:0]        cfg_reg;
   logic [7:0]        ctrl_reg     [NUM_CH];
   logic [15:0]       out_word_reg [NUM_CH];
   logic [7:0]        ack_byte_reg [NUM_CH];
   logic [15:0]       rd_word_reg  [NUM_CH];
   logic [7:0]        stat_byte    [NUM_CH];
   logic [15:0]       in_word      [NUM_CH];
   logic [NUM_CH-1:0] reg_mode_reg;
   logic [NUM_CH-1:0] pend_reg;
   logic [NUM_CH-1:0] pend_set;
   logic [NUM_CH-1:0] pend_clr;
   logic [7:0]        rd_data_reg;
   logic [7:0]        rd_mux;
   svc_state_t        svc_state_reg;
   logic [2:0]        svc_ch_reg;
   logic [5:0]        svc_num_reg;
   logic              compact;
   logic              align;
   addr_dec_t         wr_dec;
   addr_dec_t         rd_dec;
   logic              any_pend;
   logic              go;
   logic [2:0]        pick_ch;
   ctrl_byte_t        pick_cb;
   logic              mem_we;
   logic              mem_re;
   logic              mem_busy;
   logic [MEM_AW-1:0] mem_addr;
   logic [15:0]       mem_wdata;
   logic [15:0]       mem_rdata;

   // Byte offset to channel and field
   function automatic addr_dec_t decode(input logic [7:0] off,
                                        input logic       al,
                                        input logic       cp);
      addr_dec_t d;
      int        o;
      int        s;
      int        r;
      d = '0;
      o = int'(off);
      s = al ? STRIDE_ALIGNED : STRIDE_PACKED;
      r = 0;
      if (cp) begin
         // [RULE6] compact word map
         if (o < COMPACT_BYTES) begin
            d.valid = 1'b1;
            d.ch    = 3'(o / COMPACT_STRIDE);
            d.pos   = (o % COMPACT_STRIDE == 0) ? POS_LO : POS_HI;
         end
      end else if (o < (al ? ALIGN_BYTES : FULL_IN_BYTES)) begin
         // [RULE4] [RULE5] stride per layout
         d.valid = 1'b1;
         d.ch    = 3'(o / s);
         r       = o % s;
         // [RULE2] [RULE12] byte, low, high
         if (r == 0) begin
            d.pos = POS_BYTE;
         end else if (al) begin
            d.pos = (r == 1) ? POS_PAD : ((r == 2) ? POS_LO : POS_HI);
         end else begin
            d.pos = (r == 1) ? POS_LO : POS_HI;
         end
      end
      return d;
   endfunction : decode

   // Mode and address decode
   assign compact = cfg_reg[CFG_COMPACT];
   assign align   = cfg_reg[CFG_ALIGN];
   assign wr_dec  = decode(bus_addr_i, align, compact);
   assign rd_dec  = decode(bus_addr_i, align, compact);

   // Image format configuration
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cfg_reg <= CFG_RESET;
      end else if (bus_wr_i && bus_addr_i == CFG_ADDR) begin
         cfg_reg <= bus_wdata_i & CFG_MASK;
      end
   end

   // [RULE1] [RULE6] output image capture
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < NUM_CH; i++) begin
            ctrl_reg[i]     <= '0;
            out_word_reg[i] <= '0;
         end
      end else if (bus_wr_i && wr_dec.valid && !compact) begin
         case (wr_dec.pos)
            POS_BYTE: ctrl_reg[wr_dec.ch]           <= bus_wdata_i;
            POS_LO:   out_word_reg[wr_dec.ch][7:0]  <= bus_wdata_i;
            POS_HI:   out_word_reg[wr_dec.ch][15:8] <= bus_wdata_i;
            default: ;
         endcase
      end
   end

   // Service requests per channel
   always_comb begin
      pick_ch = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         pend_set[i] = bus_wr_i && wr_dec.valid && !compact &&
                       wr_dec.ch == 3'(i);
      end
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (pend_reg[i]) begin
            pick_ch = 3'(i);
         end
      end
      for (int i = 0; i < NUM_CH; i++) begin
         pend_clr[i] = go && pick_ch == 3'(i);
      end
   end

   // Pending flags, a new write wins over the clear
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pend_reg <= '0;
      end else begin
         pend_reg <= (pend_reg & ~pend_clr) | pend_set;
      end
   end

   // [RULE7] [RULE8] output word feeds register writes only
   assign any_pend  = |pend_reg;
   assign go        = svc_state_reg == SVC_IDLE && any_pend && !mem_busy;
   assign pick_cb   = ctrl_byte_t'(ctrl_reg[pick_ch]);
   assign mem_we    = go && pick_cb.reg_mode_select && pick_cb.rw;
   assign mem_re    = go && pick_cb.reg_mode_select && !pick_cb.rw;
   assign mem_addr  = {pick_ch, pick_cb.reg_num};
   assign mem_wdata = out_word_reg[pick_ch];

   // Service sequencer
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         svc_state_reg <= SVC_IDLE;
         svc_ch_reg    <= '0;
         svc_num_reg   <= '0;
      end else begin
         case (svc_state_reg)
            SVC_IDLE: begin
               if (go) begin
                  svc_ch_reg  <= pick_ch;
                  svc_num_reg <= pick_cb.reg_num;
               end
               if (mem_re) begin
                  svc_state_reg <= SVC_READ;
               end
            end
            SVC_READ: svc_state_reg <= SVC_IDLE;
            default:  svc_state_reg <= SVC_IDLE;
         endcase
      end
   end

   // [RULE9] [RULE11] per-channel acknowledge
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         reg_mode_reg <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            ack_byte_reg[i] <= '0;
            rd_word_reg[i]  <= '0;
         end
      end else begin
         if (go && !pick_cb.reg_mode_select) begin
            reg_mode_reg[pick_ch] <= 1'b0;
         end
         if (mem_we) begin
            reg_mode_reg[pick_ch] <= 1'b1;
            ack_byte_reg[pick_ch] <= {2'b11, pick_cb.reg_num};
         end
         if (svc_state_reg == SVC_READ) begin
            reg_mode_reg[svc_ch_reg] <= 1'b1;
            ack_byte_reg[svc_ch_reg] <= {2'b10, svc_num_reg};
            rd_word_reg[svc_ch_reg]  <= mem_rdata;
         end
      end
   end

   // [RULE10] input image per channel
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         stat_byte[i] = '0;
         in_word[i]   = chan_meas_i[i].value;
         if (reg_mode_reg[i] && !compact) begin
            stat_byte[i] = ack_byte_reg[i];
            in_word[i]   = rd_word_reg[i];
         end else begin
            stat_byte[i][SB_ERR_BIT]   = chan_meas_i[i].err;
            stat_byte[i][SB_OVER_BIT]  = chan_meas_i[i].over;
            stat_byte[i][SB_UNDER_BIT] = chan_meas_i[i].under;
         end
      end
   end

   // Read multiplexer, unmapped reads give zero
   always_comb begin
      rd_mux = '0;
      if (bus_addr_i == CFG_ADDR) begin
         rd_mux = cfg_reg;
      end else if (rd_dec.valid) begin
         case (rd_dec.pos)
            POS_BYTE: rd_mux = stat_byte[rd_dec.ch];
            POS_LO:   rd_mux = in_word[rd_dec.ch][7:0];
            POS_HI:   rd_mux = in_word[rd_dec.ch][15:8];
            default:  rd_mux = '0;
         endcase
      end
   end

   // Read data stand for one cycle only
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         rd_data_reg <= '0;
      end else begin
         rd_data_reg <= bus_rd_i ? rd_mux : 8'h00;
      end
   end

   assign bus_rdata_o     = rd_data_reg;
   assign chan_reg_mode_o = reg_mode_reg;

   reg_store i_reg_store (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .we_i       (mem_we),
      .re_i       (mem_re),
      .addr_i     (mem_addr),
      .wdata_i    (mem_wdata),
      .rdata_o    (mem_rdata),
      .busy_o     (mem_busy)
   );

   property p_full_size;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      bus_rd_i && !compact && !align && bus_addr_i == 8'(FULL_IN_BYTES)
      |=> rd_data_reg == 8'h00;
   endproperty
   a_full_size: assert property (p_full_size) // [RULE1]
      else $error("full image larger than 24 bytes");

   property p_status_first;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      bus_rd_i && !compact && !align && bus_addr_i == 8'h03
      |=> rd_data_reg == $past(stat_byte[1]);
   endproperty
   a_status_first: assert property (p_status_first) // [RULE2]
      else $error("status byte not before its word");

   property p_packed_last;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      bus_rd_i && !compact && !align && bus_addr_i == 8'h16
      |=> rd_data_reg == $past(in_word[7][7:0]);
   endproperty
   a_packed_last: assert property (p_packed_last) // [RULE4]
      else $error("packed last word misplaced");

   property p_aligned_last;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      bus_rd_i && !compact && align && bus_addr_i == 8'h1E
      |=> rd_data_reg == $past(in_word[7][7:0]);
   endproperty
   a_aligned_last: assert property (p_aligned_last) // [RULE5]
      else $error("aligned last word misplaced");

   property p_compact_no_out;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      bus_wr_i && compact |=> pend_reg == $past(pend_reg & ~pend_clr);
   endproperty
   a_compact_no_out: assert property (p_compact_no_out) // [RULE6]
      else $error("compact image accepted output data");

   property p_reg_traffic;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      mem_we |-> pick_cb.reg_mode_select ##1 reg_mode_reg[svc_ch_reg];
   endproperty
   a_reg_traffic: assert property (p_reg_traffic) // [RULE7]
      else $error("output word used outside register mode");

   property p_read_ack;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      mem_re |=> ##1 ack_byte_reg[svc_ch_reg] == {2'b10, svc_num_reg}
                 && rd_word_reg[svc_ch_reg] == $past(mem_rdata);
   endproperty
   a_read_ack: assert property (p_read_ack) // [RULE9]
      else $error("register read not acknowledged");

   property p_process_status;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      go && pick_ch == 3'd3 && !pick_cb.reg_mode_select && !compact
      |=> !reg_mode_reg[3] && stat_byte[3][7] == 1'b0;
   endproperty
   a_process_status: assert property (p_process_status) // [RULE10]
      else $error("process mode status bit 7 not zero");

   property p_chan_indep;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      go && pick_ch != 3'd0 |=> $stable(reg_mode_reg[0]);
   endproperty
   a_chan_indep: assert property (p_chan_indep) // [RULE11]
      else $error("service disturbed another channel");

   property p_low_first;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      bus_rd_i && !compact && !align && bus_addr_i == 8'h02
      |=> rd_data_reg == $past(in_word[0][15:8]);
   endproperty
   a_low_first: assert property (p_low_first) // [RULE12]
      else $error("high byte not at upper offset");
endmodule : image_map

// *** verif/coupler_model.sv ***
`timescale 1ns/1ps
// Coupler side of the image exchange: byte reads and writes of the image
module coupler_model (
   input  wire logic       core_clk_i,
   input  wire logic [7:0] bus_rdata_i,
   output logic      [7:0] bus_addr_o,
   output logic      [7:0] bus_wdata_o,
   output logic            bus_wr_o,
   output logic            bus_rd_o
);
   // Idle bus at time zero
   initial begin
      bus_addr_o  = 8'h00;
      bus_wdata_o = 8'h00;
      bus_wr_o    = 1'b0;
      bus_rd_o    = 1'b0;
   end

   // Released lines flip so a stale value never passes for data
   task automatic release_bus();
      bus_wr_o    <= 1'b0;
      bus_rd_o    <= 1'b0;
      bus_addr_o  <= ~bus_addr_o;
      bus_wdata_o <= ~bus_wdata_o;
   endtask : release_bus

   // One-cycle write strobe
   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      bus_wr_o    <= 1'b1;
      bus_addr_o  <= a;
      bus_wdata_o <= d;
      @(posedge core_clk_i);
      release_bus();
   endtask : wr_byte

   // One-cycle read strobe, data taken in the cycle after
   task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      bus_rd_o   <= 1'b1;
      bus_addr_o <= a;
      @(posedge core_clk_i);
      release_bus();
      #1;
      d = bus_rdata_i;
   endtask : rd_byte

   // Fill one channel of the output image, packed or aligned
   task automatic put_chan(input int c, input bit al,
                           input logic [7:0] cb, input logic [15:0] w);
      int b;
      b = al ? 4 * c : 3 * c;
      wr_byte(8'(b + 1 + al), w[7:0]);
      wr_byte(8'(b + 2 + al), w[15:8]);
      wr_byte(8'(b), cb);
   endtask : put_chan
endmodule : coupler_model

// *** verif/image_map_tb_top.sv ***
`timescale 1ns/1ps
module image_map_tb_top;
   import image_map_pkg::*;
   logic             core_clk_i = 1'b0;
   logic             sys_rst_i  = 1'b1;
   chan_meas_t [7:0] meas;
   logic [7:0]       addr;
   logic [7:0]       wdata;
   logic [7:0]       rdata;
   logic [7:0]       reg_mode;
   logic             wr;
   logic             rd;
   int               n_fail       = 0;
   int               total_checks = 0;

   always #2 core_clk_i = ~core_clk_i;

   image_map i_image_map (
      .core_clk_i      (core_clk_i),
      .sys_rst_i       (sys_rst_i),
      .bus_addr_i      (addr),
      .bus_wdata_i     (wdata),
      .bus_wr_i        (wr),
      .bus_rd_i        (rd),
      .chan_meas_i     (meas),
      .bus_rdata_o     (rdata),
      .chan_reg_mode_o (reg_mode)
   );

   coupler_model i_coupler_model (
      .core_clk_i  (core_clk_i),
      .bus_rdata_i (rdata),
      .bus_addr_o  (addr),
      .bus_wdata_o (wdata),
      .bus_wr_o    (wr),
      .bus_rd_o    (rd)
   );

   // Expected process status and value of a channel
   function automatic logic [7:0] st(input logic [2:0] c);
      return {1'b0, c[0], 4'h0, c[1], c[2] & ~c[1]};
   endfunction : st
   function automatic logic [15:0] mv(input logic [2:0] c);
      return 16'h1234 + {13'h0000, c} * 16'h1111;
   endfunction : mv

   // Distinct value on every channel, flags taken from the channel number
   initial begin : meas_init
      logic [2:0] cc;
      for (int c = 0; c < NUM_CH; c++) begin
         cc = 3'(c);
         meas[c] = {mv(cc), cc[0], cc[1], cc[2] & ~cc[1]};
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   task automatic check(input string n, input logic [15:0] s,
                        input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : check

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                         input string n);
      logic [7:0] d;
      i_coupler_model.rd_byte(a, d);
      check(n, {8'h00, d}, {8'h00, e});
   endtask : rd_chk

   // Bounded wait for a channel's register-mode flag
   task automatic wait_mode(input int c, input logic e);
      int k;
      for (k = 0; k < 40 && reg_mode[c] !== e; k++) @(posedge core_clk_i);
      check("reg_mode", {15'h0000, reg_mode[c]}, {15'h0000, e});
      if (reg_mode[c] !== e) test_done();
   endtask : wait_mode

   // Reset state, unmapped place, config field width, read pulse
   task automatic t_reset();
      check("mode_rst", {8'h00, reg_mode}, 16'h0000);
      rd_chk(CFG_ADDR, CFG_RESET, "cfg_rst");
      rd_chk(8'h80, 8'h00, "unmapped");
      i_coupler_model.wr_byte(CFG_ADDR, 8'hFF);
      rd_chk(CFG_ADDR, CFG_MASK, "cfg_mask");
      @(posedge core_clk_i);
      #1;
      check("rd_idle", {8'h00, rdata}, 16'h0000);
      i_coupler_model.wr_byte(CFG_ADDR, 8'h00);
   endtask : t_reset

   // Whole full image, packed or aligned
   task automatic t_full(input bit al);
      int          b;
      logic [15:0] w;
      i_coupler_model.wr_byte(CFG_ADDR, al ? 8'h02 : 8'h00);
      for (int c = 0; c < NUM_CH; c++) begin
         b = al ? 4 * c : 3 * c;
         w = mv(3'(c));
         rd_chk(8'(b), st(3'(c)), "status");
         if (al) rd_chk(8'(b + 1), 8'h00, "pad");
         rd_chk(8'(b + 1 + al), w[7:0], "word_lo");
         rd_chk(8'(b + 2 + al), w[15:8], "word_hi");
      end
      rd_chk(8'(al ? ALIGN_BYTES : FULL_IN_BYTES), 8'h00, "end");
   endtask : t_full

   // Compact image: words only, writes ignored
   task automatic t_compact();
      logic [15:0] w;
      i_coupler_model.wr_byte(CFG_ADDR, 8'h01);
      for (int c = 0; c < NUM_CH; c++) begin
         w = mv(3'(c));
         rd_chk(8'(2 * c), w[7:0], "cmp_lo");
         rd_chk(8'(2 * c + 1), w[15:8], "cmp_hi");
      end
      rd_chk(8'(COMPACT_BYTES), 8'h00, "cmp_end");
      i_coupler_model.wr_byte(8'h00, 8'h85);
      i_coupler_model.wr_byte(CFG_ADDR, 8'h00);
      repeat (10) @(posedge core_clk_i);
      check("cmp_nowr", {8'h00, reg_mode}, 16'h0000);
   endtask : t_compact

   // Register write and read-back, channel independence
   task automatic t_reg();
      logic [15:0] w;
      w = mv(3'h0);
      i_coupler_model.put_chan(3, 1'b0, 8'hC5, 16'h5AC3);
      wait_mode(3, 1'b1);
      rd_chk(8'h09, 8'hC5, "wr_ack");
      // Control byte alone: rewriting the word in write mode would overwrite
      i_coupler_model.wr_byte(8'h09, 8'h85);
      repeat (4) @(posedge core_clk_i);
      rd_chk(8'h09, 8'h85, "rd_ack");
      rd_chk(8'h0A, 8'hC3, "rd_lo");
      rd_chk(8'h0B, 8'h5A, "rd_hi");
      i_coupler_model.put_chan(4, 1'b0, 8'h85, 16'hFFFF);
      wait_mode(4, 1'b1);
      repeat (4) @(posedge core_clk_i);
      rd_chk(8'h0D, 8'h00, "own_reg");
      i_coupler_model.put_chan(0, 1'b0, 8'h00, 16'hA5A5);
      repeat (4) @(posedge core_clk_i);
      rd_chk(8'h01, w[7:0], "no_pd_out");
      i_coupler_model.put_chan(3, 1'b0, 8'h00, 16'h0000);
      wait_mode(3, 1'b0);
      rd_chk(8'h09, st(3'h3), "back_pd");
      check("mode_map", {8'h00, reg_mode}, 16'h0010);
   endtask : t_reg

   // Main sequence
   initial begin
      repeat (8) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      // Register store clears itself after reset
      repeat (600) @(posedge core_clk_i);
      for (int c = 0; c < NUM_CH; c++) begin
         i_coupler_model.put_chan(c, 1'b0, 8'h00, 16'h0000);
      end
      repeat (40) @(posedge core_clk_i);
      t_full(1'b0);
      t_full(1'b1);
      t_compact();
      t_reg();
      test_done();
   end
endmodule : image_map_tb_top
